// [rtl/eg_pkg.sv]
// Constants, field layout and types of the entropy generator.
// Assumes a 32-bit register bus with byte addresses.
package eg_pkg;
    localparam int          ADDR_W      = 8;
    localparam int          DATA_W      = 32;
    localparam logic [7:0]  OFS_CONTROL = 8'h00;
    localparam logic [7:0]  OFS_CONFIG  = 8'h04;
    localparam logic [7:0]  OFS_LOW     = 8'h0C;
    localparam logic [7:0]  OFS_HIGH    = 8'h10;
    localparam logic [7:0]  OFS_STATUS  = 8'h14;
    localparam logic [7:0]  OFS_MASK    = 8'h18;
    localparam int          EN_BIT      = 0;
    localparam int          START_BIT   = 1;
    localparam int          SRC_LSB     = 0;
    localparam int          SRC_W       = 2;
    localparam int          SHIFT_LSB   = 2;
    localparam int          SHIFT_W     = 3;
    localparam int          DONE_BIT    = 0;
    localparam int          HIGH_LSB    = 32;
    localparam logic [2:0]  SHIFT_RST   = 3'h4;
    localparam logic [1:0]  SRC_RST     = 2'h0;
    localparam logic [8:0]  CNT_ONE     = 9'h001;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    // Arbitrary nonzero start state
    localparam logic [63:0] LFSR_SEED   = 64'h5A5A_0F0F_C3C3_1234;
    // Taps for x^64 + x^63 + x^61 + x^60 + 1
    localparam logic [63:0] LFSR_TAPS   = 64'hD800_0000_0000_0000;

    typedef enum logic [1:0] {EG_SRC_FEEDBACK, EG_SRC_ENTROPY, EG_SRC_MIXED, EG_SRC_UNDEF} eg_src_t;
    typedef enum logic {EG_IDLE, EG_RUN} eg_state_t;

    function automatic logic [8:0] eg_shift_count(input logic [2:0] code);
        unique case (code)
            3'h1:    eg_shift_count = 9'h008;
            3'h2:    eg_shift_count = 9'h010;
            3'h3:    eg_shift_count = 9'h020;
            3'h5:    eg_shift_count = 9'h080;
            3'h6:    eg_shift_count = 9'h100;
            default: eg_shift_count = 9'h040;
        endcase
    endfunction
endpackage

// [rtl/eg_regbus_if.sv]
// Register strobe bundle between the bus slave and the register file.
// Assumes one clock; strobes last one cycle.
`timescale 1ns/100ps
interface eg_regbus_if;
    logic                      wr_en;
    logic [eg_pkg::ADDR_W-1:0] wr_addr;
    logic [eg_pkg::DATA_W-1:0] wr_data;
    logic [3:0]                wr_strb;
    logic                      wr_hit;
    logic                      rd_en;
    logic [eg_pkg::ADDR_W-1:0] rd_addr;
    logic [eg_pkg::DATA_W-1:0] rd_data;
    logic                      rd_hit;
    modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, input wr_hit, rd_data, rd_hit);
    modport regs  (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, output wr_hit, rd_data, rd_hit);
endinterface

// [rtl/eg_axil_slave.sv]
// AXI4-Lite slave turning bus transfers into one-cycle register strobes.
// Assumes the register side answers a read in the strobe cycle.
`timescale 1ns/100ps
module eg_axil_slave (
    input  wire logic        i_clk,      // System clock
    input  wire logic        i_arst_n,   // Async reset
    input  wire logic        i_awvalid,  // Write address valid
    output logic             o_awready,  // Write address ready
    input  wire logic [7:0]  i_awaddr,   // Write address
    input  wire logic        i_wvalid,   // Write data valid
    output logic             o_wready,   // Write data ready
    input  wire logic [31:0] i_wdata,    // Write data
    input  wire logic [3:0]  i_wstrb,    // Byte enables
    output logic             o_bvalid,   // Write response valid
    input  wire logic        i_bready,   // Write response ready
    output logic [1:0]       o_bresp,    // Write response
    input  wire logic        i_arvalid,  // Read address valid
    output logic             o_arready,  // Read address ready
    input  wire logic [7:0]  i_araddr,   // Read address
    output logic             o_rvalid,   // Read data valid
    input  wire logic        i_rready,   // Read data ready
    output logic [31:0]      o_rdata,    // Read data
    output logic [1:0]       o_rresp,    // Read response
    eg_regbus_if.slave       bus         // Register strobes
);
    logic [7:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    wire logic   do_write = !o_awready && !o_wready && !o_bvalid;
    wire logic   rd_go    = i_arvalid && o_arready;

    assign bus.wr_en   = do_write;
    assign bus.wr_addr = awaddr_reg;
    assign bus.wr_data = wdata_reg;
    assign bus.wr_strb = wstrb_reg;
    assign bus.rd_en   = rd_go;
    assign bus.rd_addr = i_araddr;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_awready  <= 1'b1;
            awaddr_reg <= 8'h00;
        end else if (i_awvalid && o_awready) begin
            o_awready  <= 1'b0;
            awaddr_reg <= i_awaddr;
        end else if (do_write) begin
            o_awready  <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_wready  <= 1'b1;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else if (i_wvalid && o_wready) begin
            o_wready  <= 1'b0;
            wdata_reg <= i_wdata;
            wstrb_reg <= i_wstrb;
        end else if (do_write) begin
            o_wready  <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_bvalid <= 1'b0;
            o_bresp  <= eg_pkg::RESP_OKAY;
        end else if (do_write) begin
            o_bvalid <= 1'b1;
            o_bresp  <= bus.wr_hit ? eg_pkg::RESP_OKAY : eg_pkg::RESP_SLVERR;
        end else if (i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h0000_0000;
            o_rresp   <= eg_pkg::RESP_OKAY;
        end else if (rd_go) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rdata   <= bus.rd_data;
            o_rresp   <= bus.rd_hit ? eg_pkg::RESP_OKAY : eg_pkg::RESP_SLVERR;
        end else if (o_rvalid && i_rready) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
        end
    end

    a_bresp_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped before bready");
endmodule

// [rtl/eg_lfsr.sv]
// 64-bit shift register with selectable serial input.
// Assumes the entropy bit is already synchronised to i_clk.
`timescale 1ns/100ps
module eg_lfsr (
    input  wire logic        i_clk,      // System clock
    input  wire logic        i_arst_n,   // Async reset
    input  wire logic        i_shift,    // Shift once
    input  wire logic [1:0]  i_src,      // Input select code
    input  wire logic        i_entropy,  // Synchronised entropy bit
    output logic [63:0]      o_state     // Current contents
);
    // All-zero state would lock pure feedback mode, so force a one in
    wire logic fb_bit = (^(o_state & eg_pkg::LFSR_TAPS)) | (o_state == '0);
    logic       in_bit;

    always_comb begin
        unique case (eg_pkg::eg_src_t'(i_src))
            eg_pkg::EG_SRC_ENTROPY: in_bit = i_entropy;
            eg_pkg::EG_SRC_MIXED:   in_bit = i_entropy ^ fb_bit;
            default:                in_bit = fb_bit;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_state <= eg_pkg::LFSR_SEED;
        end else if (i_shift) begin
            o_state <= {o_state[62:0], in_bit};
        end
    end

    a_src_entropy: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_shift && i_src == 2'h1 |=> o_state[0] == $past(i_entropy) && o_state[63:1] == $past(o_state[62:0]))
        else $error("entropy input not shifted in");
    a_src_mixed: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_shift && i_src == 2'h2 |=> o_state[0] == ($past(i_entropy) ^ $past(fb_bit)))
        else $error("mixed input wrong");
    a_src_undef: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_shift && (i_src == 2'h3 || i_src == 2'h0) |=> o_state[0] == $past(fb_bit))
        else $error("feedback input wrong");
endmodule

// [rtl/eg_entropy_generator.sv]
// Entropy generator: control registers, shift sequencer and interrupt.
// Assumes an AXI4-Lite master on i_clk and an asynchronous entropy bit.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
module eg_entropy_generator (
    input  wire logic        i_clk,            // 10 MHz system clock
    input  wire logic        i_arst_n,         // Async reset, active low
    input  wire logic        i_bus_clock_gate, // Clock gate enable
    input  wire logic        i_entropy_bit,    // Analog source output
    input  wire logic        i_awvalid,        // Write address valid
    output logic             o_awready,        // Write address ready
    input  wire logic [7:0]  i_awaddr,         // Write address
    input  wire logic        i_wvalid,         // Write data valid
    output logic             o_wready,         // Write data ready
    input  wire logic [31:0] i_wdata,          // Write data
    input  wire logic [3:0]  i_wstrb,          // Byte enables
    output logic             o_bvalid,         // Write response valid
    input  wire logic        i_bready,         // Write response ready
    output logic [1:0]       o_bresp,          // Write response
    input  wire logic        i_arvalid,        // Read address valid
    output logic             o_arready,        // Read address ready
    input  wire logic [7:0]  i_araddr,         // Read address
    output logic             o_rvalid,         // Read data valid
    input  wire logic        i_rready,         // Read data ready
    output logic [31:0]      o_rdata,          // Read data
    output logic [1:0]       o_rresp,          // Read response
    output logic             o_source_enable,  // Analog source power
    output logic             o_irq             // Level interrupt
);
    eg_regbus_if rb ();

    eg_axil_slave u_slave (
        .i_clk     (i_clk),
        .i_arst_n  (i_arst_n),
        .i_awvalid (i_awvalid),
        .o_awready (o_awready),
        .i_awaddr  (i_awaddr),
        .i_wvalid  (i_wvalid),
        .o_wready  (o_wready),
        .i_wdata   (i_wdata),
        .i_wstrb   (i_wstrb),
        .o_bvalid  (o_bvalid),
        .i_bready  (i_bready),
        .o_bresp   (o_bresp),
        .i_arvalid (i_arvalid),
        .o_arready (o_arready),
        .i_araddr  (i_araddr),
        .o_rvalid  (o_rvalid),
        .i_rready  (i_rready),
        .o_rdata   (o_rdata),
        .o_rresp   (o_rresp),
        .bus       (rb.slave)
    );

    logic                  ent_meta_reg;
    logic                  ent_sync_reg;
    eg_pkg::eg_state_t     state_reg;
    eg_pkg::eg_state_t     state_next;
    logic [8:0]            count_reg;
    logic [8:0]            count_next;
    logic [1:0]            run_src_reg;
    logic [2:0]            cfg_shift_reg;
    logic [1:0]            cfg_src_reg;
    logic                  done_sts_reg;
    logic                  done_sts_next;
    logic                  done_mask_reg;
    logic [63:0]           lfsr_state;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ent_meta_reg <= 1'b0;
            ent_sync_reg <= 1'b0;
        end else begin
            ent_meta_reg <= i_entropy_bit;
            ent_sync_reg <= ent_meta_reg;
        end
    end

    // Address decode; all fields sit in byte lane 0
    wire logic lane0      = rb.wr_strb[0];
    wire logic a_ctrl     = rb.wr_addr == eg_pkg::OFS_CONTROL;
    wire logic a_cfg      = rb.wr_addr == eg_pkg::OFS_CONFIG;
    wire logic a_mask     = rb.wr_addr == eg_pkg::OFS_MASK;
    wire logic a_ro       = rb.wr_addr == eg_pkg::OFS_LOW || rb.wr_addr == eg_pkg::OFS_HIGH
                            || rb.wr_addr == eg_pkg::OFS_STATUS;
    // A closed clock gate freezes the registers, but a status read still clears completion; the bus still answers
    wire logic wr_go      = rb.wr_en && lane0 && i_bus_clock_gate;
    wire logic wr_control = wr_go && a_ctrl;
    wire logic wr_config  = wr_go && a_cfg;
    wire logic wr_mask    = wr_go && a_mask;
    wire logic rd_status  = rb.rd_en && rb.rd_addr == eg_pkg::OFS_STATUS;
    wire logic busy       = state_reg == eg_pkg::EG_RUN;
    wire logic start_req  = wr_control && rb.wr_data[eg_pkg::START_BIT];

    wire logic start_go   = start_req && !busy;
    wire logic step       = busy && i_bus_clock_gate;

    wire logic last_step  = step && count_reg == eg_pkg::CNT_ONE;

    assign rb.wr_hit = a_ctrl || a_cfg || a_mask || a_ro;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            eg_pkg::EG_IDLE: if (start_go) begin
                state_next = eg_pkg::EG_RUN;
            end
            eg_pkg::EG_RUN: if (last_step) begin
                state_next = eg_pkg::EG_IDLE;
            end
        endcase
    end

    // codes 0 and 7 mean 64
    assign count_next = start_go ? eg_pkg::eg_shift_count(cfg_shift_reg)
                      : step ? 9'(count_reg - eg_pkg::CNT_ONE) : count_reg;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg   <= eg_pkg::EG_IDLE;
            count_reg   <= 9'h000;
            run_src_reg <= eg_pkg::SRC_RST;
        end else begin
            state_reg   <= state_next;
            count_reg   <= count_next;
            run_src_reg <= start_go ? cfg_src_reg : run_src_reg;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_source_enable <= 1'b0;
        end else if (wr_control) begin
            o_source_enable <= rb.wr_data[eg_pkg::EN_BIT];
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cfg_shift_reg <= eg_pkg::SHIFT_RST;
            cfg_src_reg   <= eg_pkg::SRC_RST;
        end else if (wr_config) begin
            cfg_shift_reg <= rb.wr_data[eg_pkg::SHIFT_LSB +: eg_pkg::SHIFT_W];
            cfg_src_reg   <= rb.wr_data[eg_pkg::SRC_LSB +: eg_pkg::SRC_W];
        end
    end

    // Completion is sticky; a completion in the clearing read's cycle wins
    assign done_sts_next = last_step || (done_sts_reg && !rd_status);

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            done_sts_reg  <= 1'b0;
            done_mask_reg <= 1'b0;
            o_irq         <= 1'b0;
        end else begin
            done_sts_reg  <= done_sts_next;
            done_mask_reg <= wr_mask ? rb.wr_data[eg_pkg::DONE_BIT] : done_mask_reg;
            o_irq         <= done_sts_next && (wr_mask ? rb.wr_data[eg_pkg::DONE_BIT] : done_mask_reg);
        end
    end

    eg_lfsr u_lfsr (
        .i_clk     (i_clk),
        .i_arst_n  (i_arst_n),
        .i_shift   (step),
        .i_src     (run_src_reg),
        .i_entropy (ent_sync_reg),
        .o_state   (lfsr_state)
    );

    // Read words
    wire logic [31:0] ctrl_word = 32'(o_source_enable) << eg_pkg::EN_BIT
                                | 32'(busy) << eg_pkg::START_BIT;
    wire logic [31:0] cfg_word  = 32'(cfg_shift_reg) << eg_pkg::SHIFT_LSB
                                | 32'(cfg_src_reg) << eg_pkg::SRC_LSB;
    wire logic [31:0] sts_word  = 32'(done_sts_reg) << eg_pkg::DONE_BIT;
    wire logic [31:0] mask_word = 32'(done_mask_reg) << eg_pkg::DONE_BIT;
    wire logic        r_ctrl    = rb.rd_addr == eg_pkg::OFS_CONTROL;
    wire logic        r_cfg     = rb.rd_addr == eg_pkg::OFS_CONFIG;
    wire logic        r_low     = rb.rd_addr == eg_pkg::OFS_LOW;
    wire logic        r_high    = rb.rd_addr == eg_pkg::OFS_HIGH;
    wire logic        r_sts     = rb.rd_addr == eg_pkg::OFS_STATUS;
    wire logic        r_mask    = rb.rd_addr == eg_pkg::OFS_MASK;

    assign rb.rd_hit  = r_ctrl || r_cfg || r_low || r_high || r_sts || r_mask;

    assign rb.rd_data = r_ctrl ? ctrl_word
                      : r_cfg  ? cfg_word
                      : r_low  ? lfsr_state[31:0]
                      : r_high ? lfsr_state[eg_pkg::HIGH_LSB +: eg_pkg::DATA_W]
                      : r_sts  ? sts_word
                      : r_mask ? mask_word
                      : 32'h0000_0000;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    a_source_follows: assert property (wr_control |=>
        o_source_enable == $past(rb.wr_data[eg_pkg::EN_BIT]))
        else $error("source enable does not follow control write");
    a_start_launch: assert property (start_go |=> busy [*8])
        else $error("start did not launch a run");
    a_done_clears: assert property (last_step |=> !busy ##0 done_sts_reg)
        else $error("start bit not cleared at completion");
    a_low_word: assert property (rb.rd_en && r_low |=> o_rdata == $past(lfsr_state[31:0]))
        else $error("low word mismatch");
    a_high_word: assert property (rb.rd_en && r_high |=>
        o_rdata == $past(lfsr_state[63:32]))
        else $error("high word mismatch");
    a_count_eight: assert property (start_go && cfg_shift_reg == 3'h1 |=> count_reg == 9'h008)
        else $error("code 1 did not load 8 shifts");
    a_count_max: assert property (start_go && cfg_shift_reg == 3'h6 |=> count_reg == 9'h100)
        else $error("code 6 did not load 256 shifts");
    a_count_undef: assert property (start_go && (cfg_shift_reg == 3'h0 || cfg_shift_reg == 3'h7)
        |=> count_reg == 9'h040)
        else $error("undefined code did not load 64 shifts");
    a_no_restart: assert property (start_req && busy && count_reg > eg_pkg::CNT_ONE && i_bus_clock_gate
        |=> busy && count_reg == $past(count_reg) - 9'h001)
        else $error("start accepted while running");
    a_reset_cfg: assert property ($rose(i_arst_n) |->
        cfg_shift_reg == 3'h4 && cfg_src_reg == 2'h0)
        else $error("config reset value wrong");
    a_reset_ctrl: assert property ($rose(i_arst_n) |-> !o_source_enable && !busy && !o_irq)
        else $error("control reset value wrong");
    a_run_time: assert property (start_go && cfg_shift_reg == 3'h1 ##1 i_bus_clock_gate [*8]
        |=> !busy)
        else $error("eight-shift run took the wrong time");
    a_irq_level: assert property (o_irq == (done_sts_reg && done_mask_reg))
        else $error("interrupt does not follow unmasked status");

    c_start: cover property (start_go);
    c_done: cover property (last_step);
    c_read_low: cover property (rb.rd_en && r_low && !busy);
    c_irq: cover property ($rose(o_irq));
endmodule

// [verif/testbench.sv]
// Self-checking bench for the entropy generator, driven over AXI4-Lite.
// Assumes eg_pkg and the design files are compiled first; the bench drives every input.
`timescale 1ns/100ps
module testbench;
    logic        clk, rst_n, gate, ent, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, src_en, irq;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d, lo0, hi0;
    logic [1:0]  bresp, rresp, r, b;
    int          n_mismatch, total_checks;
    int          tbl [8] = '{64, 8, 16, 32, 64, 128, 256, 64};

    eg_entropy_generator dut (.i_clk(clk), .i_arst_n(rst_n), .i_bus_clock_gate(gate), .i_entropy_bit(ent),
        .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
        .i_wdata(wdata), .i_wstrb(4'hF), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
        .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
        .o_rdata(rdata), .o_rresp(rresp), .o_source_enable(src_en), .o_irq(irq));

    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic hang();
        n_mismatch++;
        report_and_stop();
    endtask

    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Address and data are offered together and released one by one as taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bit aw, w;
        int k;
        aw = 1; w = 1; k = 0;
        awvalid <= 1; wvalid <= 1; awaddr <= a; wdata <= v; bready <= 1;
        while (aw || w) begin
            @(posedge clk);
            if (aw && awready === 1'b1) begin aw = 0; awvalid <= 0; end
            if (w && wready === 1'b1) begin w = 0; wvalid <= 0; end
            if (++k > 50) hang();
        end
        do begin @(posedge clk); if (++k > 50) hang(); end while (bvalid !== 1'b1);
        b = bresp;
    endtask

    task automatic rd(input logic [7:0] a);
        int k;
        k = 0;
        arvalid <= 1; araddr <= a; rready <= 1;
        do begin @(posedge clk); if (++k > 50) hang(); end while (arready !== 1'b1);
        arvalid <= 0;
        do begin @(posedge clk); if (++k > 50) hang(); end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
    endtask

    // One generation with interrupt timing; optional second start while running
    task automatic run(input logic [2:0] c, input logic [1:0] s, input int n, input bit again);
        realtime t0;
        int k;
        wr(8'h04, {27'h0, c, s});
        wr(8'h00, 32'h3);
        t0 = $realtime;
        if (again) begin repeat (100) @(posedge clk); wr(8'h00, 32'h3); end
        k = 0;
        while (irq !== 1'b1) begin @(posedge clk); if (++k > 400) hang(); end
        k = int'(($realtime - t0) / 100.0);
        check("shift_cycles", k, n);
        rd(8'h14); check("status", d, 1);
        repeat (2) @(posedge clk); check("irq_cleared", irq, 0);
    endtask

    initial begin
        n_mismatch = 0; total_checks = 0;
        rst_n = 0; gate = 1; ent = 1;
        awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
        repeat (4) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        rd(8'h00); check("control_reset", d, 32'h0000_0000);
        rd(8'h04); check("config_reset", d, 32'h0000_0010);
        check("source_off", src_en, 0);
        rd(8'h20); check("unmapped_resp", r, 2'h2);
        check("unmapped_data", d, 32'h0000_0000);
        wr(8'h20, 32'h0); check("unmapped_wr_resp", b, 2'h2);
        $display("Test reset and map done");
        wr(8'h18, 32'h1);
        for (int c = 0; c < 8; c++) run(c[2:0], 2'h1, tbl[c], 0);
        check("source_on", src_en, 1);
        rd(8'h0C); check("low_word", d, 32'hFFFF_FFFF);
        wr(8'h0C, 32'h0);
        check("ro_write_resp", b, 2'h0);
        rd(8'h0C); check("low_read_only", d, 32'hFFFF_FFFF);
        wr(8'h10, 32'h0);
        rd(8'h10); check("high_word", d, 32'hFFFF_FFFF);
        $display("Test shift counts done");
        run(3'h4, 2'h0, 64, 0);
        rd(8'h0C); lo0 = d; rd(8'h10); hi0 = d;
        run(3'h4, 2'h1, 64, 0);
        run(3'h4, 2'h3, 64, 0);
        rd(8'h0C); check("undef_src_low", d, lo0);
        rd(8'h10); check("undef_src_high", d, hi0);
        run(3'h4, 2'h1, 64, 0);
        run(3'h4, 2'h2, 64, 0);
        rd(8'h0C); check("mixed_differs", d !== lo0, 1);
        run(3'h6, 2'h1, 256, 1);
        gate <= 0;
        wr(8'h04, 32'h0000_0004);
        rd(8'h04); check("gated_config", d, 32'h0000_0019);
        gate <= 1;
        $display("Test input select done");
        wr(8'h18, 32'h0);
        wr(8'h00, 32'h3);
        rd(8'h00); check("start_running", d[1], 1);
        for (int k = 0; d[1] !== 1'b0; k++) begin rd(8'h00); if (k > 300) hang(); end
        check("masked_irq", irq, 0);
        rd(8'h14); check("masked_status", d, 1);
        wr(8'h00, 32'h0); check("source_released", src_en, 0);
        $display("Test polling and mask done");
        report_and_stop();
    end
endmodule
